// ===== wft_map.svh
`ifndef WFT_MAP_SVH
`define WFT_MAP_SVH

// register byte offsets (own choice, aligned words)
`define WFT_CTRL_OFS 8'h00
`define WFT_STAT_OFS 8'h04
`define WFT_CFG_OFS 8'h08

// control register layout
`define WFT_ACT_BIT 7
`define WFT_TOP_BIT 6
`define WFT_CTRL_RST 8'h7F

// status register layout
`define WFT_STAT_ACTIVE_BIT 0
`define WFT_STAT_RSTOUT_BIT 1
`define WFT_STAT_CAUSE_LSB 2

// timing
`define WFT_PRESCALE_CYCLES 16000
`define WFT_CLK_MHZ 25
`define WFT_RST_PULSE_NS 30000
`define WFT_CLK_NS 40
`define WFT_RST_PULSE_CYCLES ((`WFT_RST_PULSE_NS + `WFT_CLK_NS - 1) / `WFT_CLK_NS)

`endif

// ===== wft_pkg.sv
package wft_pkg;

    typedef enum logic [1:0] {
        WFT_CAUSE_NONE,
        WFT_CAUSE_EXPIRY,
        WFT_CAUSE_SOFT,
        WFT_CAUSE_HALT
    } wft_cause_t;

    typedef enum logic [1:0] {
        WFT_IDLE,
        WFT_WDATA,
        WFT_WADDR,
        WFT_BRESP
    } wft_wr_state_t;

    typedef struct packed {
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
    } wft_wreq_t;

    typedef struct packed {
        wft_wr_state_t wst;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic wr_fire;
    } wft_bus_state_t;

endpackage : wft_pkg

// ===== wft_pulse_gen.sv
`timescale 1ns/1ps
`include "wft_map.svh"

// holds the reset request busy output high for a fixed cycle count
module wft_pulse_gen (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic start,
    output logic busy
);

    localparam int unsigned CYC = `WFT_RST_PULSE_CYCLES;

    typedef struct packed {
        logic [9:0] cnt;
        logic busy;
    } wft_pulse_state_t;

    wft_pulse_state_t s_q;
    wft_pulse_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (s_q.busy) begin
            if (s_q.cnt == 10'h001) begin
                s_d.busy = 1'b0;
            end
            s_d.cnt = s_q.cnt - 10'h001;
        end else if (start) begin
            s_d.busy = 1'b1;
            s_d.cnt = 10'(CYC);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;

endmodule : wft_pulse_gen

// ===== wft_top.sv
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "wft_map.svh"

// What this block does
// - the seven-bit counter drops by one every 16000 clock cycles of the prescaler.
// - when active and the counter steps from 40h to 3Fh a chip reset starts.
// - a watchdog reset drives the reset line low for about 30 us.
// - the counter keeps counting while inactive; only the reset is gated.
// - the six low counter bits give the remaining prescaler periods, 64 steps.
// - after an aresetn reset the timer is inactive unless the always-on option is set; its own reset pulse leaves it active.
// - once the activation bit is set the timer stays active until a reset.
// - writing activation set with top bit clear resets at once.
// - halt with an active timer resets unless the halt option forbids it.
// - a configuration option selects reset on halt or a normal halt.
// - with the always-on option the timer is always active and the bit is unused.
// - at 8 MHz code C0h gives up to 2 ms and FFh 126 to 128 ms.
// - control holds activation in bit 7 and counter in bits 6 to 0, reset 7Fh.
// - the activation bit is set by software only and cleared by reset only.
module wft_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic hw_always_on,
    input wire logic halt_no_reset,
    input wire logic halt_req,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic chip_reset_n,
    output logic halt_grant
);

    // --------------------------------------------------------------
    // option straps, caught by clock after reset release
    // --------------------------------------------------------------
    logic [2:0] hw_sync_q;
    logic [2:0] hnr_sync_q;
    logic [2:0] halt_sync_q;
    logic hw_opt_q;
    logic hnr_opt_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hw_sync_q <= 3'h0;
            hnr_sync_q <= 3'h0;
            halt_sync_q <= 3'h0;
            hw_opt_q <= 1'b0;
            hnr_opt_q <= 1'b0;
        end else begin
            hw_sync_q <= {hw_sync_q[1:0], hw_always_on};
            hnr_sync_q <= {hnr_sync_q[1:0], halt_no_reset};
            halt_sync_q <= {halt_sync_q[1:0], halt_req};
            // straps keep their last agreed level while the pins settle
            if (hw_sync_q[2] == hw_sync_q[1]) begin
                hw_opt_q <= hw_sync_q[2];
            end
            if (hnr_sync_q[2] == hnr_sync_q[1]) begin
                hnr_opt_q <= hnr_sync_q[2];
            end
        end
    end

    // level, not edge: a halt still held after a pulse triggers again
    logic halt_seen;
    assign halt_seen = halt_sync_q[2] & halt_sync_q[1];

    // --------------------------------------------------------------
    // watchdog core and bus state
    // --------------------------------------------------------------
    typedef struct packed {
        logic act;
        logic [6:0] cnt;
        logic [13:0] pre;
        logic fire;
        wft_pkg::wft_cause_t cause;
        logic halt_grant;
        logic rst_n;
    } wft_core_t;

    wft_core_t c_q;
    wft_core_t c_d;
    wft_pkg::wft_bus_state_t b_q;
    wft_pkg::wft_bus_state_t b_d;

    // the prescaler wraps on its last count, so a tick is one cycle wide
    localparam logic [13:0] PRE_LAST = 14'(`WFT_PRESCALE_CYCLES - 1);

    logic pulse_busy;
    logic active;
    logic ctrl_wr;
    logic [7:0] wr_byte;
    logic tick;

    // the strap overrides the software bit, which then has no effect
    assign active = c_q.act | hw_opt_q;
    // a cleared byte strobe leaves the control word alone
    assign ctrl_wr = b_q.wr_fire && (b_q.awaddr == `WFT_CTRL_OFS) && b_q.wstrb[0];
    assign wr_byte = b_q.wdata[7:0];
    assign tick = (c_q.pre == PRE_LAST);

    // --------------------------------------------------------------
    // counter, triggers and halt
    // --------------------------------------------------------------
    always_comb begin
        c_d = c_q;
        c_d.fire = 1'b0;
        // free-running prescaler, never touched by writes
        c_d.pre = tick ? 14'h0000 : c_q.pre + 14'h0001;
        // a refresh in the tick cycle wins, so a late write still saves the chip
        if (ctrl_wr) begin
            c_d.cnt = wr_byte[6:0];
            if (wr_byte[`WFT_ACT_BIT]) begin
                c_d.act = 1'b1;
            end
            if (wr_byte[`WFT_ACT_BIT] && !wr_byte[`WFT_TOP_BIT] && !pulse_busy) begin
                c_d.fire = 1'b1;
                c_d.cause = wft_pkg::WFT_CAUSE_SOFT;
            end
        end else if (tick) begin
            c_d.cnt = c_q.cnt - 7'h01;
            if (active && c_q.cnt == 7'h40 && !pulse_busy) begin
                c_d.fire = 1'b1;
                c_d.cause = wft_pkg::WFT_CAUSE_EXPIRY;
            end
        end
        c_d.halt_grant = 1'b0;
        if (halt_seen) begin
            if (active && !hnr_opt_q) begin
                if (!pulse_busy && !c_q.fire) begin
                    c_d.fire = 1'b1;
                    c_d.cause = wft_pkg::WFT_CAUSE_HALT;
                end
            end else if (!pulse_busy && !c_q.fire) begin
                // no grant while the chip is being reset anyway
                c_d.halt_grant = 1'b1;
            end
        end
        // triggers that land during the pulse are dropped, never queued
        c_d.rst_n = !(pulse_busy | c_q.fire);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            c_q <= '0;
            c_q.cnt <= 7'(`WFT_CTRL_RST);
            c_q.rst_n <= 1'b1;
        end else begin
            c_q <= c_d;
        end
    end

    // --------------------------------------------------------------
    // reset pulse timer
    // --------------------------------------------------------------
    wft_pulse_gen u_pulse (
        .aclk(aclk),
        .aresetn(aresetn),
        .start(c_q.fire),
        .busy(pulse_busy)
    );

    // --------------------------------------------------------------
    // axi4-lite slave
    // --------------------------------------------------------------
    logic [31:0] rd_val;
    logic rd_ok;

    always_comb begin
        rd_val = 32'h0000_0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == `WFT_CTRL_OFS) begin
            rd_val = {24'h000000, c_q.act, c_q.cnt};
        end else if (s_axi_araddr == `WFT_STAT_OFS) begin
            // cause keeps the last trigger until the block is reset
            rd_val = {28'h0000000, c_q.cause, !c_q.rst_n, active};
        end else if (s_axi_araddr == `WFT_CFG_OFS) begin
            rd_val = {30'h00000000, hnr_opt_q, hw_opt_q};
        end else begin
            rd_ok = 1'b0;
        end
    end

    // --------------------------------------------------------------
    // write and read channels
    // --------------------------------------------------------------
    always_comb begin
        b_d = b_q;
        b_d.wr_fire = 1'b0;
        case (b_q.wst)
            wft_pkg::WFT_IDLE: begin
                if (s_axi_awvalid && s_axi_wvalid) begin
                    b_d.awaddr = s_axi_awaddr;
                    b_d.wdata = s_axi_wdata;
                    b_d.wstrb = s_axi_wstrb;
                    b_d.awready = 1'b0;
                    b_d.wready = 1'b0;
                    b_d.wr_fire = 1'b1;
                    b_d.wst = wft_pkg::WFT_BRESP;
                end else if (s_axi_awvalid) begin
                    b_d.awaddr = s_axi_awaddr;
                    b_d.awready = 1'b0;
                    b_d.wst = wft_pkg::WFT_WDATA;
                end else if (s_axi_wvalid) begin
                    b_d.wdata = s_axi_wdata;
                    b_d.wstrb = s_axi_wstrb;
                    b_d.wready = 1'b0;
                    b_d.wst = wft_pkg::WFT_WADDR;
                end
            end
            wft_pkg::WFT_WDATA: begin
                if (s_axi_wvalid) begin
                    b_d.wdata = s_axi_wdata;
                    b_d.wstrb = s_axi_wstrb;
                    b_d.wready = 1'b0;
                    b_d.wr_fire = 1'b1;
                    b_d.wst = wft_pkg::WFT_BRESP;
                end
            end
            wft_pkg::WFT_WADDR: begin
                if (s_axi_awvalid) begin
                    b_d.awaddr = s_axi_awaddr;
                    b_d.awready = 1'b0;
                    b_d.wr_fire = 1'b1;
                    b_d.wst = wft_pkg::WFT_BRESP;
                end
            end
            default: begin
                if (b_q.wr_fire) begin
                    b_d.bvalid = 1'b1;
                    // writes to the read-only words are accepted and dropped
                    if (b_q.awaddr == `WFT_CTRL_OFS) begin
                        b_d.bresp = 2'h0;
                    end else if (b_q.awaddr == `WFT_STAT_OFS) begin
                        b_d.bresp = 2'h0;
                    end else if (b_q.awaddr == `WFT_CFG_OFS) begin
                        b_d.bresp = 2'h0;
                    end else begin
                        b_d.bresp = 2'h3;
                    end
                end else if (b_q.bvalid && s_axi_bready) begin
                    b_d.bvalid = 1'b0;
                    b_d.awready = 1'b1;
                    b_d.wready = 1'b1;
                    b_d.wst = wft_pkg::WFT_IDLE;
                end
            end
        endcase
        if (b_q.rvalid) begin
            if (s_axi_rready) begin
                b_d.rvalid = 1'b0;
                b_d.arready = 1'b1;
            end
        end else if (s_axi_arvalid && b_q.arready) begin
            b_d.arready = 1'b0;
            b_d.rvalid = 1'b1;
            b_d.rdata = rd_val;
            b_d.rresp = rd_ok ? 2'h0 : 2'h3;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            b_q <= '0;
            b_q.wst <= wft_pkg::WFT_IDLE;
            b_q.awready <= 1'b1;
            b_q.wready <= 1'b1;
            b_q.arready <= 1'b1;
        end else begin
            b_q <= b_d;
        end
    end

    // --------------------------------------------------------------
    // registered outputs
    // --------------------------------------------------------------
    assign s_axi_awready = b_q.awready;
    assign s_axi_wready = b_q.wready;
    assign s_axi_bvalid = b_q.bvalid;
    assign s_axi_bresp = b_q.bresp;
    assign s_axi_arready = b_q.arready;
    assign s_axi_rvalid = b_q.rvalid;
    assign s_axi_rdata = b_q.rdata;
    assign s_axi_rresp = b_q.rresp;
    assign chip_reset_n = c_q.rst_n;
    assign halt_grant = c_q.halt_grant;

endmodule : wft_top

// ===== wft_assertions.sv
`timescale 1ns/1ps
// ------------------------------
// port checks of the fault timer
// ------------------------------
module wft_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic halt_req,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic chip_reset_n,
    input wire logic halt_grant
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic [11:0] low_q;
    // too long to unroll, so count low cycles here
    always_ff @(posedge aclk) begin
        if (!aresetn || chip_reset_n) begin
            low_q <= 12'h000;
        end else begin
            low_q <= low_q + 12'h001;
        end
    end
    pulse_min_a: assert property ($rose(chip_reset_n) |-> low_q >= 12'h2EF)
        else $error("reset pulse too short");
    pulse_max_a: assert property (low_q <= 12'h2F1)
        else $error("reset pulse too long");
    grant_safe_a: assert property (halt_grant |-> chip_reset_n)
        else $error("halt granted while resetting");
    grant_drop_a: assert property (!halt_req [*8] |-> !halt_grant)
        else $error("halt grant without halt");
    soft_reset_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && chip_reset_n
        && s_axi_awaddr == 8'h00 && s_axi_wstrb[0] && s_axi_wdata[7:6] == 2'b10
        |-> ##[1:8] !chip_reset_n) else $error("soft reset missing");
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    resp_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    ctrl_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
        |=> s_axi_rvalid && s_axi_rresp == 2'h0 && s_axi_rdata[31:8] == 24'h000000)
        else $error("control read wrong");
    unmapped_read_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h08
        |=> s_axi_rvalid && s_axi_rresp == 2'h3) else $error("unmapped read not refused");
    cover property ($rose(chip_reset_n));
    cover property (halt_grant);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h3);
endmodule : wft_checker

bind wft_top wft_checker u_chk (.aclk, .aresetn, .halt_req, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .chip_reset_n, .halt_grant);

// ===== wft_core_model.sv
`timescale 1ns/1ps
// ------------------------------
// reset receiver on the far side
// ------------------------------
module wft_core_model (
    input wire logic aclk,
    input wire logic chip_reset_n,
    output logic [11:0] low_len
);
    logic [11:0] cnt_q = 12'h000;
    logic [11:0] len_q = 12'h000;
    assign low_len = len_q;
    // only a level is seen; the bench judges the width
    always @(posedge aclk) begin
        if (!chip_reset_n) begin
            cnt_q <= cnt_q + 12'h001;
        end else begin
            if (cnt_q != 12'h000) begin
                len_q <= cnt_q;
            end
            cnt_q <= 12'h000;
        end
    end
endmodule : wft_core_model

// ===== windowed_fault_watchdog_test.sv
`timescale 1ns/1ps
module windowed_fault_watchdog_test;
    logic aclk = 1'b0;
    logic aresetn, hw_always_on, halt_no_reset, halt_req, chip_reset_n, halt_grant;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] low_len;
    logic [6:0] c1;
    int n_errors = 0;
    int total_checks = 0;
    int n;
    always #20 aclk = ~aclk;
    wft_top dut (.aclk, .aresetn, .hw_always_on, .halt_no_reset, .halt_req, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chip_reset_n, .halt_grant);
    wft_core_model u_gen (.aclk, .chip_reset_n, .low_len);
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic do_reset;
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
    endtask : do_reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        s_axi_bready <= 1'b0;
        br = s_axi_bresp;
        chk("write done", 32'h1, {31'h0, s_axi_bvalid});
        if (s_axi_bvalid !== 1'b1) tally_and_finish();
    endtask : wr
    task automatic rd_reg(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        chk("read done", 32'h1, {31'h0, s_axi_rvalid});
        if (s_axi_rvalid !== 1'b1) tally_and_finish();
    endtask : rd_reg
    task automatic wait_lvl(input logic lvl, input int lim);
        for (n = 0; n < lim && chip_reset_n !== lvl; n++) @(posedge aclk);
        chk("reset line", {31'h0, lvl}, {31'h0, chip_reset_n});
        if (chip_reset_n !== lvl) tally_and_finish();
    endtask : wait_lvl
    task automatic t_regs;
        rd_reg(8'h00);
        chk("ctrl reset", 32'h0000007F, rd);
        rd_reg(8'h0C);
        chk("unmapped resp", 32'h3, {30'h0, rr});
        wr(8'h0C, 32'h000000FF);
        chk("unmapped write", 32'h3, {30'h0, br});
        wr(8'h00, 32'h0000003F);
        chk("ctrl write resp", 32'h0, {30'h0, br});
        repeat (10) @(posedge aclk);
        chk("no reset inactive", 32'h1, {31'h0, chip_reset_n});
        rd_reg(8'h00);
        chk("act after zero", 32'h0, {31'h0, rd[7]});
        c1 = rd[6:0];
        // ar-to-ar span of the two reads is 16002 cycles, two more than one prescaler period
        repeat (15999) @(posedge aclk);
        rd_reg(8'h00);
        chk("one tick", {25'h0, c1 - 7'h01}, {25'h0, rd[6:0]});
    endtask : t_regs
    task automatic t_soft;
        wr(8'h00, 32'h00000080);
        wait_lvl(1'b0, 20);
        wait_lvl(1'b1, 800);
        @(posedge aclk);
        chk("pulse len", 32'h1, {31'h0, low_len >= 12'h2EF && low_len <= 12'h2F1});
        rd_reg(8'h04);
        chk("soft cause", 32'h9, {28'h0, rd[3:0]});
        do_reset();
        rd_reg(8'h00);
        chk("inactive after reset", 32'h0, {31'h0, rd[7]});
    endtask : t_soft
    task automatic t_expiry;
        wr(8'h00, 32'h000000FF);
        wr(8'h00, 32'h0000007F);
        rd_reg(8'h00);
        chk("act sticky", 32'h1, {31'h0, rd[7]});
        wr(8'h00, 32'h000000C1);
        wait_lvl(1'b0, 32010);
        chk("expiry not early", 32'h1, {31'h0, n >= 15990});
        wait_lvl(1'b1, 800);
        do_reset();
    endtask : t_expiry
    task automatic t_halt;
        halt_no_reset <= 1'b1;
        do_reset();
        wr(8'h00, 32'h000000FF);
        halt_req <= 1'b1;
        repeat (12) @(posedge aclk);
        chk("normal halt", 32'h3, {30'h0, halt_grant, chip_reset_n});
        halt_req <= 1'b0;
        halt_no_reset <= 1'b0;
        repeat (12) @(posedge aclk);
        chk("grant released", 32'h0, {31'h0, halt_grant});
        halt_req <= 1'b1;
        wait_lvl(1'b0, 20);
        halt_req <= 1'b0;
        wait_lvl(1'b1, 800);
        hw_always_on <= 1'b1;
        do_reset();
        rd_reg(8'h04);
        chk("always on", 32'h1, {31'h0, rd[0]});
        rd_reg(8'h08);
        chk("cfg straps", 32'h1, {30'h0, rd[1:0]});
        halt_req <= 1'b1;
        wait_lvl(1'b0, 20);
        halt_req <= 1'b0;
        hw_always_on <= 1'b0;
        wait_lvl(1'b1, 800);
    endtask : t_halt
    initial begin
        {aresetn, hw_always_on, halt_no_reset, halt_req} <= 4'h0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 48'h0;
        s_axi_wstrb <= 4'hF;
        do_reset();
        t_regs();
        t_soft();
        t_expiry();
        t_halt();
        tally_and_finish();
    end
endmodule : windowed_fault_watchdog_test
